// [pitx_buf.sv]
// shift-register fifo: head entry is always slot zero, so data leaves a flop
// assumes source and sink share clk_i
`timescale 1ns/1ns
module pitx_buf #(
  parameter int unsigned W     = 10,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic         clk_i,       // clock
  input  wire logic         rst_i,       // sync reset
  input  wire logic [W-1:0] in_data_i,   // word in
  input  wire logic         in_valid_i,  // word offered
  output wire logic         in_ready_o,  // room left
  output wire logic [W-1:0] out_data_o,  // head word
  output wire logic         out_valid_o, // head valid
  input  wire logic         out_ready_i  // sink takes head
);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [CW-1:0]           cnt;
    logic                    nemp;
  } pitx_buf_t;
  pitx_buf_t r, n;
  logic                    push, pop;
  logic [CW-1:0]           wr;
  logic [DEPTH-1:0][W-1:0] mem_nx;
  assign in_ready_o  = r.cnt != CW'(DEPTH);
  assign out_valid_o = r.nemp;
  assign out_data_o  = r.mem[0];
  assign pop  = r.nemp & out_ready_i;
  assign push = in_valid_i & in_ready_o;
  assign wr   = pop ? r.cnt - CW'(1) : r.cnt;
  // ****************
  // per-entry shift and fill
  // ****************
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_comb begin
      mem_nx[i] = (pop && i < DEPTH - 1) ? r.mem[(i + 1) % DEPTH] : r.mem[i];
      if (push && wr == CW'(i)) begin
        mem_nx[i] = in_data_i;
      end
    end
  end
  always_comb begin
    n      = r;
    n.mem  = mem_nx;
    n.cnt  = r.cnt + CW'(push) - CW'(pop);
    n.nemp = n.cnt != '0;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

// [pitx_nib.sv]
// data nibble of each identification field; pure combinational map
// assumes its field and configuration inputs are registered by the caller; offset and self-test inputs come in raw
`timescale 1ns/1ns
module pitx_nib #(
  parameter logic [7:0] PROD_REV = 8'h00 // arbitrary factory value
) (
  input  wire logic [4:0]  field_i, // field index
  input  wire logic        ext_i,   // init_extended_enable
  input  wire logic        ordy_i,  // raw offset available
  input  wire logic        srdy_i,  // self-test value available
  input  wire logic [9:0]  off_i,   // raw offset
  input  wire logic [9:0]  st_i,    // averaged_selftest_value
  input  wire logic [7:0]  mfg_i,   // manufacturer id
  input  wire logic [1:0]  axis_i,  // axis direction
  input  wire logic [1:0]  rsel_i,  // range select
  input  wire logic [7:0]  cfg1_i,  // device_config_one
  input  wire logic [7:0]  cfg2_i,  // device_config_two
  input  wire logic [7:0]  cfg6_i,  // device_config_six
  input  wire logic [6:0]  jy_i,    // julian_year
  input  wire logic [3:0]  jm_i,    // julian_month
  input  wire logic [4:0]  jd_i,    // julian_day
  input  wire logic [31:0] ser_i,   // serial bytes 0..3, byte 0 low
  output logic      [3:0]  nib_o    // data nibble
);
  import pitx_pkg::*;
  logic [4:0] si;
  logic [7:0] sb;
  logic [9:0] og, sg;
  assign si = field_i - F_SN;
  assign sb = ser_i[8*si[2:1] +: 8];
  // offset and self-test only when extended and already measured
  assign og = (ext_i && ordy_i) ? off_i : '0;
  assign sg = (ext_i && srdy_i) ? st_i : '0;
  always_comb begin
    unique case (field_i)
      F_REV:   nib_o = REV_CODE;
      F_NBH:   nib_o = NBLK_CODE[7:4];
      F_NBL:   nib_o = NBLK_CODE[3:0];
      F_MFH:   nib_o = mfg_i[7:4];
      F_MFL:   nib_o = mfg_i[3:0];
      F_TYH:   nib_o = TYPE_CODE[7:4];
      F_TYL:   nib_o = TYPE_CODE[3:0];
      F_AXS:   nib_o = {axis_i, 2'h0};
      F_RNG:   nib_o = RNG_BASE + {2'h0, rsel_i};
      F_S2H:   nib_o = cfg2_i[7:4];
      F_S2L:   nib_o = cfg2_i[3:0];
      F_PRH:   nib_o = PROD_REV[7:4];
      F_PRL:   nib_o = PROD_REV[3:0];
      F_C6:    nib_o = cfg6_i[3:0];
      F_JD0:   nib_o = jy_i[6:3];
      F_JD1:   nib_o = {jy_i[2:0], jm_i[3]};
      F_JD2:   nib_o = {jm_i[2:0], jd_i[4]};
      F_JD3:   nib_o = jd_i[3:0];
      F_OFL:   nib_o = og[3:0];
      F_OFM:   nib_o = og[7:4];
      F_MIX:   nib_o = {sg[1:0], og[9:8]};
      F_STM:   nib_o = sg[5:2];
      F_STH:   nib_o = sg[9:6];
      F_LAST:  nib_o = ext_i ? cfg1_i[7:4] : '0;
      default: nib_o = si[0] ? sb[3:0] : sb[7:4];
    endcase
  end
endmodule

// [pitx_pkg.sv]
// constants for the phase-2 identification message framer (10-bit mode)
// assumes a single 125 MHz clock and a classic wishbone register port
package pitx_pkg;
  // ****************
  // word format
  // ****************
  localparam int unsigned WORD_W    = 10;
  localparam logic [5:0]  ID_PFX    = 6'h20;
  localparam logic [5:0]  DAT_PFX   = 6'h21;
  localparam logic [4:0]  F_LAST    = 5'h1F;
  // ****************
  // fixed codes
  // ****************
  localparam logic [3:0]  REV_CODE  = 4'h4;
  localparam logic [7:0]  NBLK_CODE = 8'h20;
  localparam logic [7:0]  TYPE_CODE = 8'h01;
  localparam logic [3:0]  RNG_BASE  = 4'h7;
  // ****************
  // field indices
  // ****************
  localparam logic [4:0]  F_REV = 5'h00, F_NBH = 5'h01, F_NBL = 5'h02;
  localparam logic [4:0]  F_MFH = 5'h03, F_MFL = 5'h04, F_TYH = 5'h05;
  localparam logic [4:0]  F_TYL = 5'h06, F_AXS = 5'h07, F_RNG = 5'h08;
  localparam logic [4:0]  F_S2H = 5'h09, F_S2L = 5'h0A, F_PRH = 5'h0B;
  localparam logic [4:0]  F_PRL = 5'h0C, F_C6  = 5'h0D, F_JD0 = 5'h0E;
  localparam logic [4:0]  F_JD1 = 5'h0F, F_JD2 = 5'h10, F_JD3 = 5'h11;
  localparam logic [4:0]  F_SN  = 5'h12, F_SNE = 5'h19, F_OFL = 5'h1A;
  localparam logic [4:0]  F_OFM = 5'h1B, F_MIX = 5'h1C, F_STM = 5'h1D;
  localparam logic [4:0]  F_STH = 5'h1E;
  // ****************
  // register map
  // ****************
  localparam logic [7:0]  A_CTRL = 8'h00, A_STAT = 8'h04, A_CONF = 8'h08;
  localparam logic [7:0]  A_DCFG = 8'h0C, A_DATE = 8'h10, A_SER  = 8'h14;
  localparam logic [7:0]  A_RES  = 8'h18;
  localparam int unsigned C_START = 0, C_EXT = 1, C_ABORT = 2;
  localparam int unsigned S_BUSY = 0, S_DONE = 1, S_FLD = 8, S_REP = 16;
  localparam int unsigned K_POS = 0, AX_POS = 4, RG_POS = 6, MF_POS = 8;
  localparam int unsigned C1_POS = 0, C2_POS = 8, C6_POS = 16;
  localparam int unsigned JY_POS = 0, JM_POS = 8, JD_POS = 16;
  localparam int unsigned OF_POS = 0, ST_POS = 16, OR_POS = 28, SR_POS = 29;
  localparam logic [3:0]  K_RST = 4'h4;
  typedef enum logic {PITX_IDLE, PITX_RUN} pitx_state_t;
endpackage

// [pitx_sink.sv]
// far-side model of the message sink: takes one word per cycle or stalls
// assumes it shares clk_i and rst_i with the framer
`timescale 1ns/1ns
module pitx_sink (
  input  wire logic clk_i,   // clock
  input  wire logic rst_i,   // sync reset
  input  wire logic stall_i, // allow random stalls
  output logic      ready_o  // word taken when valid is high too
);
  // ****************
  // ready
  // ****************
  // random stalls exercise the two-entry buffer from both sides
  always_ff @(posedge clk_i) begin
    if (rst_i) ready_o <= 1'b0;
    else ready_o <= stall_i ? 1'($urandom % 2) : 1'b1;
  end
endmodule

// [pitx_top.sv]
// phase-2 identification message framer, 10-bit mode, wishbone controlled
// assumes the line transmitter drains tx words one per sync slot
//
// What this block does
// - each field goes out as its identifier word, then its data word
// - fields 1 to 32 in ascending order, each pair repeated k times, or once when k is zero
// - field 1 carries protocol revision code 0100
// - fields 2 and 3 carry block count 0010 0000, high nibble first
// - fields 6 and 7 carry sensor type 0000 0001
// - field 8 is the axis setting shifted left by two
// - field 9 is range code 0111, 1000, 1001 or 1010
// - fields 15 to 18 carry the julian date, year, month, day, msb first
// - fields 27 to 31 carry raw offset then self-test value, else zero
// - field 32 carries config one upper nibble when extended, else zero
// - offset and self-test go out only once their phases have finished
// - results not yet available are sent as zero nibbles
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
module pitx_top
  import pitx_pkg::*;
#(
  parameter logic [7:0]  PROD_REV = 8'h00, // arbitrary factory value
  parameter int unsigned BUF_D    = 2      // output buffer depth
) (
  input  wire logic                        clk_i,            // 125 MHz
  input  wire logic                        rst_i,            // sync reset
  input  wire logic                        wb_cyc_i,         // bus cycle
  input  wire logic                        wb_stb_i,         // strobe
  input  wire logic                        wb_we_i,          // write
  input  wire logic [7:0]                  wb_adr_i,         // byte address
  input  wire logic [3:0]                  wb_sel_i,         // byte lanes
  input  wire logic [31:0]                 wb_dat_i,         // write data
  output wire logic [31:0]                 wb_dat_o,         // read data
  output wire logic                        wb_ack_o,         // ack
  input  wire logic [9:0]                  raw_offset_i,     // raw offset
  input  wire logic                        offset_ready_i,   // offset done
  input  wire logic [9:0]                  selftest_value_i, // avg self-test
  input  wire logic                        selftest_ready_i, // self-test done
  output wire logic [pitx_pkg::WORD_W-1:0] tx_data_o,        // message word
  output wire logic                        tx_valid_o,       // word valid
  input  wire logic                        tx_ready_i,       // word taken
  output wire logic                        busy_o            // sequence on
);
  import pitx_pkg::*;
  // ****************
  // state
  // ****************
  typedef struct packed {
    pitx_state_t st;
    logic [4:0]  field;
    logic [3:0]  rep;
    logic        ph;
    logic        ext;
    logic [3:0]  k;
    logic [1:0]  axis;
    logic [1:0]  rsel;
    logic [7:0]  mfg;
    logic [7:0]  cfg1;
    logic [7:0]  cfg2;
    logic [7:0]  cfg6;
    logic [6:0]  jy;
    logic [3:0]  jm;
    logic [4:0]  jd;
    logic [31:0] ser;
    logic        busy;
    logic        done;
    logic        ack;
    logic [31:0] rdat;
    logic [9:0]  lw;
    logic [4:0]  lf;
    logic        lwv;
  } pitx_regs_t;
  pitx_regs_t r, n;
  logic              req, wr, abort_w, push, in_rdy;
  logic [3:0]        nib;
  logic [9:0]        pw;
  logic [4:0]        rep1;
  logic [31:0]       conf_img, dcfg_img, date_img, stat_img, res_img;
  // byte-lane merge for writes
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        m[8*b +: 8] = d[8*b +: 8];
      end
    end
    return m;
  endfunction
  // ****************
  // register images
  // ****************
  always_comb begin
    conf_img = '0;
    conf_img[K_POS +: 4]  = r.k;
    conf_img[AX_POS +: 2] = r.axis;
    conf_img[RG_POS +: 2] = r.rsel;
    conf_img[MF_POS +: 8] = r.mfg;
    dcfg_img = '0;
    dcfg_img[C1_POS +: 8] = r.cfg1;
    dcfg_img[C2_POS +: 8] = r.cfg2;
    dcfg_img[C6_POS +: 8] = r.cfg6;
    date_img = '0;
    date_img[JY_POS +: 7] = r.jy;
    date_img[JM_POS +: 4] = r.jm;
    date_img[JD_POS +: 5] = r.jd;
    stat_img = '0;
    stat_img[S_BUSY]      = r.busy;
    stat_img[S_DONE]      = r.done;
    stat_img[S_FLD +: 5]  = r.field;
    stat_img[S_REP +: 4]  = r.rep;
    res_img = '0;
    res_img[OF_POS +: 10] = raw_offset_i;
    res_img[ST_POS +: 10] = selftest_value_i;
    res_img[OR_POS]       = offset_ready_i;
    res_img[SR_POS]       = selftest_ready_i;
  end
  // ****************
  // bus decode
  // ****************
  // ack is registered, so a request is answered in the following cycle
  assign req     = wb_cyc_i & wb_stb_i & ~r.ack;
  assign wr      = req & wb_we_i;
  assign abort_w = wr && wb_adr_i == A_CTRL && wb_sel_i[0] && wb_dat_i[C_ABORT];
  // ****************
  // word source
  // ****************
  pitx_nib #(
    .PROD_REV (PROD_REV)
  ) u_nib (
    .field_i (r.field),
    .ext_i   (r.ext),
    .ordy_i  (offset_ready_i),
    .srdy_i  (selftest_ready_i),
    .off_i   (raw_offset_i),
    .st_i    (selftest_value_i),
    .mfg_i   (r.mfg),
    .axis_i  (r.axis),
    .rsel_i  (r.rsel),
    .cfg1_i  (r.cfg1),
    .cfg2_i  (r.cfg2),
    .cfg6_i  (r.cfg6),
    .jy_i    (r.jy),
    .jm_i    (r.jm),
    .jd_i    (r.jd),
    .ser_i   (r.ser),
    .nib_o   (nib)
  );
  // identifier carries the low four bits of the field index
  assign pw   = r.ph ? {DAT_PFX, nib} : {ID_PFX, r.field[3:0]};
  assign push = r.st == PITX_RUN && !abort_w && in_rdy;
  assign rep1 = {1'b0, r.rep} + 5'h01;
  // a stalled transmitter holds the sequencer, no word is dropped
  pitx_buf #(
    .W     (WORD_W),
    .DEPTH (BUF_D)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   (pw),
    .in_valid_i  (r.st == PITX_RUN && !abort_w),
    .in_ready_o  (in_rdy),
    .out_data_o  (tx_data_o),
    .out_valid_o (tx_valid_o),
    .out_ready_i (tx_ready_i)
  );
  // ****************
  // next state
  // ****************
  always_comb begin
    logic        start, dclr, dset;
    logic [31:0] m;
    start = 1'b0;
    dclr  = 1'b0;
    dset  = 1'b0;
    m     = '0;
    n     = r;
    n.ack = req;
    if (req) begin
      unique case (wb_adr_i)
        A_CTRL:  n.rdat = {30'h0, r.ext, 1'b0};
        A_STAT:  n.rdat = stat_img;
        A_CONF:  n.rdat = conf_img;
        A_DCFG:  n.rdat = dcfg_img;
        A_DATE:  n.rdat = date_img;
        A_SER:   n.rdat = r.ser;
        A_RES:   n.rdat = res_img;
        default: n.rdat = '0;
      endcase
    end
    if (wr) begin
      unique case (wb_adr_i)
        A_CTRL: begin
          if (wb_sel_i[0]) begin
            start = wb_dat_i[C_START];
            n.ext = wb_dat_i[C_EXT];
          end
        end
        A_STAT: begin
          dclr = wb_sel_i[0] && wb_dat_i[S_DONE];
        end
        A_CONF: begin
          m      = wmerge(conf_img, wb_dat_i, wb_sel_i);
          n.k    = m[K_POS +: 4];
          n.axis = m[AX_POS +: 2];
          n.rsel = m[RG_POS +: 2];
          n.mfg  = m[MF_POS +: 8];
        end
        A_DCFG: begin
          m      = wmerge(dcfg_img, wb_dat_i, wb_sel_i);
          n.cfg1 = m[C1_POS +: 8];
          n.cfg2 = m[C2_POS +: 8];
          n.cfg6 = m[C6_POS +: 8];
        end
        A_DATE: begin
          m    = wmerge(date_img, wb_dat_i, wb_sel_i);
          n.jy = m[JY_POS +: 7];
          n.jm = m[JM_POS +: 4];
          n.jd = m[JD_POS +: 5];
        end
        A_SER: begin
          n.ser = wmerge(r.ser, wb_dat_i, wb_sel_i);
        end
        default: begin
        end
      endcase
    end
    unique case (r.st)
      PITX_IDLE: begin
        if (start) begin
          n.st    = PITX_RUN;
          n.busy  = 1'b1;
          n.field = '0;
          n.rep   = '0;
          n.ph    = 1'b0;
          n.lwv   = 1'b0;
        end
      end
      PITX_RUN: begin
        if (abort_w) begin
          n.st   = PITX_IDLE;
          n.busy = 1'b0;
        end else if (push) begin
          n.lw  = pw;
          n.lf  = r.field;
          n.lwv = 1'b1;
          n.ph  = ~r.ph;
          if (r.ph) begin
            // k of zero is taken as one pass
            if (rep1 >= {1'b0, r.k}) begin
              n.rep = '0;
              if (r.field == F_LAST) begin
                n.st   = PITX_IDLE;
                n.busy = 1'b0;
                dset   = 1'b1;
              end else begin
                n.field = r.field + 5'h01;
              end
            end else begin
              n.rep = rep1[3:0];
            end
          end
        end
      end
    endcase
    // completion beats a clear in the same cycle
    n.done = (r.done & ~dclr) | dset;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r   <= '0;
      r.k <= K_RST;
    end else begin
      r <= n;
    end
  end
  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.rdat;
  assign busy_o   = r.busy;
  // ****************
  // checks
  // ****************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  id_before_data_a: assert property (
    push && pw[9:4] == DAT_PFX |-> r.lwv && r.lw == {ID_PFX, r.field[3:0]})
    else $error("data word not preceded by its identifier");
  field_ascend_a: assert property (
    push && r.lwv && !r.ph |-> r.field == r.lf || r.field == r.lf + 5'h01)
    else $error("field order broken");
  field_repeat_a: assert property (
    push && r.ph && r.k != 4'h0 && r.rep < r.k - 4'h1 |=> r.field == $past(r.field))
    else $error("field left before k repeats");
  rev_code_a: assert property (
    push && r.ph && r.field == F_REV |-> pw == {DAT_PFX, 4'h4})
    else $error("wrong protocol revision");
  block_count_a: assert property (
    push && r.ph && r.field == F_NBH |-> pw[3:0] == 4'h2)
    else $error("wrong block count high nibble");
  sensor_type_a: assert property (
    push && r.ph && r.field == F_TYL |-> pw[3:0] == 4'h1)
    else $error("wrong sensor type");
  axis_code_a: assert property (
    push && r.ph && r.field == F_AXS |-> pw[3:0] == {r.axis, 2'h0})
    else $error("wrong axis code");
  range_code_a: assert property (
    push && r.ph && r.field == F_RNG |-> pw[3:0] inside {4'h7, 4'h8, 4'h9, 4'hA})
    else $error("range code out of set");
  date_year_a: assert property (
    push && r.ph && r.field == F_JD0 |-> pw[3:0] == r.jy[6:3])
    else $error("julian year nibble wrong");
  ext_zero_a: assert property (
    push && r.ph && !r.ext && r.field >= F_OFL |-> pw[3:0] == 4'h0)
    else $error("extended field not zero");
  early_zero_a: assert property (
    push && r.ph && r.field == F_OFL && !offset_ready_i |-> pw[3:0] == 4'h0)
    else $error("offset sent before available");
  serial_first_a: assert property (
    push && r.ph && r.field == F_SN |-> pw[3:0] == r.ser[7:4])
    else $error("serial byte zero high nibble wrong");
  block_low_a: assert property (
    push && r.ph && r.field == F_NBL |-> pw[3:0] == 4'h0)
    else $error("wrong block count low nibble");
  prod_rev_a: assert property (
    push && r.ph && r.field == F_PRH |-> pw[3:0] == PROD_REV[7:4])
    else $error("product revision high nibble wrong");
  st_zero_a: assert property (
    push && r.ph && r.field == F_STH && !selftest_ready_i |-> pw[3:0] == 4'h0)
    else $error("self-test sent before available");
  last_field_a: assert property (
    push && r.ph && r.ext && r.field == F_LAST |-> pw[3:0] == r.cfg1[7:4])
    else $error("last field not config one upper nibble");
  // a word the sink has not taken must stay put, or the stream loses it
  word_hold_a: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("unaccepted word changed");
  run_done_c: cover property ($fell(r.busy) && r.done);
  tx_stall_c: cover property (tx_valid_o && !tx_ready_i && !in_rdy && r.busy);
  ext_data_c: cover property (push && r.ph && r.ext && r.field == F_STH && selftest_ready_i);
  abort_c: cover property (abort_w && r.busy);
endmodule

// [pitx_top_tb_top.sv]
// self-checking bench of the phase-2 message framer
// assumes the sink model drives tx_ready_i and bus answers come within 50 cycles
`timescale 1ns/1ns
module pitx_top_tb_top;
  import pitx_pkg::*;
  localparam logic [7:0] PR = 8'h5A; // arbitrary product revision
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, rd;
  logic [31:0] wdo;
  logic        ack, tx_ready, tx_valid, busy, stall = 1'b0;
  logic [9:0]  off = 10'h0, st = 10'h0, tx_data;
  logic        ordy = 1'b0, srdy = 1'b0, ext;
  logic [7:0]  mfg, c1, c2, c6;
  logic [6:0]  jy;
  logic [3:0]  jm, k;
  logic [4:0]  jd;
  logic [1:0]  axis, rsel;
  logic [31:0] ser;
  logic [9:0]  exp_q[$];
  logic [7:0]  ra[5] = '{A_CTRL, A_STAT, A_CONF, A_DCFG, 8'h1C};
  int          mismatches = 0, n_compared = 0;

  always #4 clk_i = ~clk_i;

  pitx_top #(.PROD_REV(PR), .BUF_D(2)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack),
    .raw_offset_i(off), .offset_ready_i(ordy), .selftest_value_i(st),
    .selftest_ready_i(srdy), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
    .tx_ready_i(tx_ready), .busy_o(busy));

  pitx_sink sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .ready_o(tx_ready));

  // ****************
  // checking
  // ****************
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // each handshake takes the oldest expected word
  always @(posedge clk_i) begin
    if (!rst_i && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exp_q.size() == 0) check("extra word", {22'h0, tx_data}, 32'h0);
      else check("tx word", {22'h0, tx_data}, {22'h0, exp_q.pop_front()});
    end
  end

  // ****************
  // bus and model
  // ****************
  task automatic wb_io(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      complete_run();
    end
  endtask

  function automatic logic [3:0] nib(input int f);
    logic [9:0] o, s;
    logic [7:0] b;
    o = (ext && ordy) ? off : 10'h0;
    s = (ext && srdy) ? st : 10'h0;
    b = ser[8*((f-18)/2) +: 8];
    case (f)
      0: return 4'h4;
      1: return 4'h2;
      3: return mfg[7:4];
      4: return mfg[3:0];
      6: return 4'h1;
      7: return {axis, 2'b00};
      8: return 4'h7 + {2'b00, rsel};
      9: return c2[7:4];
      10: return c2[3:0];
      11: return PR[7:4];
      12: return PR[3:0];
      13: return c6[3:0];
      14: return jy[6:3];
      15: return {jy[2:0], jm[3]};
      16: return {jm[2:0], jd[4]};
      17: return jd[3:0];
      26: return o[3:0];
      27: return o[7:4];
      28: return {s[1:0], o[9:8]};
      29: return s[5:2];
      30: return s[9:6];
      31: return ext ? c1[7:4] : 4'h0;
      default: return (f >= 18 && f <= 25) ? ((f % 2 == 0) ? b[7:4] : b[3:0]) : 4'h0;
    endcase
  endfunction

  // k of zero is one pass
  task automatic fill_exp();
    for (int f = 0; f < 32; f++) begin
      for (int j = 0; j < ((k == 0) ? 1 : k); j++) begin
        exp_q.push_back({ID_PFX, 4'(f)});
        exp_q.push_back({DAT_PFX, nib(f)});
      end
    end
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    int n;
    void'($urandom(8));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ra[j]) begin
      wb_io(ra[j], 1'b0, 32'h0, rd);
      check("reset value", rd, (ra[j] == A_CONF) ? 32'h4 : 32'h0);
    end
    wb_io(8'h1C, 1'b1, 32'hFFFFFFFF, rd);
    wb_io(8'h1C, 1'b0, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      axis = 2'(i); rsel = 2'(i); k = 4'(i); ext = (i != 0);
      {mfg, c1, c2, c6} = $urandom;
      {jy, jm, jd} = 16'($urandom);
      ser = $urandom;
      off <= 10'($urandom); st <= 10'($urandom);
      ordy <= (i != 2); srdy <= (i != 3); stall <= i[0];
      wb_io(A_CONF, 1'b1, {16'h0, mfg, rsel, axis, k}, rd);
      wb_io(A_DCFG, 1'b1, {8'h0, c6, c2, c1}, rd);
      wb_io(A_DATE, 1'b1, {11'h0, jd, 4'h0, jm, 1'b0, jy}, rd);
      wb_io(A_SER, 1'b1, ser, rd);
      wb_io(A_CONF, 1'b0, 32'h0, rd);
      check("conf", rd, {16'h0, mfg, rsel, axis, k});
      wb_io(A_RES, 1'b0, 32'h0, rd);
      check("res", rd, {2'b00, srdy, ordy, 2'b00, st, 6'h00, off});
      fill_exp();
      wb_io(A_CTRL, 1'b1, {30'h0, ext, 1'b1}, rd);
      check("busy", {31'h0, busy}, 32'h1);
      // a second start while running must not restart the sequence
      wb_io(A_CTRL, 1'b1, {30'h0, ext, 1'b1}, rd);
      n = 0;
      while ((busy !== 1'b0 || exp_q.size() != 0 || tx_valid !== 1'b0) && n < 20000) begin
        @(posedge clk_i);
        n++;
      end
      if (n >= 20000) begin
        mismatches++;
        complete_run();
      end
      wb_io(A_STAT, 1'b0, 32'h0, rd);
      check("done", rd & 32'h3, 32'h2);
      wb_io(A_STAT, 1'b1, 32'h2, rd);
      wb_io(A_STAT, 1'b0, 32'h0, rd);
      check("done clear", rd & 32'h3, 32'h0);
      wb_io(A_CTRL, 1'b0, 32'h0, rd);
      check("ctrl", rd, {30'h0, ext, 1'b0});
    end
    // abort part way: buffered words still leave, then the stream stops short
    fill_exp();
    wb_io(A_CTRL, 1'b1, {30'h0, ext, 1'b1}, rd);
    wb_io(A_CTRL, 1'b1, {29'h0, 1'b1, ext, 1'b0}, rd);
    n = 0;
    while ((busy !== 1'b0 || tx_valid !== 1'b0) && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 100) begin
      mismatches++;
      complete_run();
    end
    check("abort cut", 32'(exp_q.size() != 0), 32'h1);
    wb_io(A_STAT, 1'b0, 32'h0, rd);
    check("abort status", rd & 32'h3, 32'h0);
    exp_q.delete();
    complete_run();
  end
endmodule
